// ---- verilog/bsp_regs.vh ----
`ifndef BSP_REGS_VH
`define BSP_REGS_VH

// register offsets on the plain register port
`define BSP_ADDR_W           8
`define BSP_OFS_DATA         8'h08
`define BSP_OFS_CTRL_DATA    8'h09
`define BSP_OFS_DIR          8'h88
`define BSP_OFS_CTRL         8'h89
`define BSP_OFS_EVT_STATUS   8'h8A
`define BSP_OFS_EVT_MASK     8'h8B

// control and status register fields
`define BSP_CTRL_IN_FULL     7
`define BSP_CTRL_OUT_FULL    6
`define BSP_CTRL_OVF         5
`define BSP_CTRL_MODE        4
`define BSP_CTRL_DIR_HI      2
`define BSP_CTRL_DIR_LO      0

// control pin positions
`define BSP_PIN_RD           0
`define BSP_PIN_WR           1
`define BSP_PIN_CS           2

// event status bits
`define BSP_EVT_W            3
`define BSP_EVT_WRITE_DONE   0
`define BSP_EVT_READ_DONE    1
`define BSP_EVT_OVERFLOW     2

// reset values
`define BSP_RST_DATA         8'h00
`define BSP_RST_DIR          8'hFF
`define BSP_RST_CTRL_DIR     3'h7
`define BSP_RST_CTRL_DATA    3'h0
`define BSP_RST_EVT          3'h0
`define BSP_RST_BYTE         8'h00
`define BSP_RST_FLAG         1'h0
`define BSP_CTRL_IDLE_PINS   3'h7

`endif

// ---- verilog/bsp_sync.v ----
`timescale 1ns/100ps
module bsp_sync #(
    parameter             WIDTH = 8,
    parameter [WIDTH-1:0] INIT  = {WIDTH{1'b0}}
) (
    input  wire             clk_sys,
    input  wire             rst,
    input  wire [WIDTH-1:0] async_in,
    output reg  [WIDTH-1:0] sync_out
);

    reg [WIDTH-1:0] stage_one;

    // stage_one is read only by sync_out
    always @(posedge clk_sys) begin
        if (rst) begin
            stage_one <= INIT;
            sync_out  <= INIT;
        end else begin
            stage_one <= async_in;
            sync_out  <= stage_one;
        end
    end

endmodule

// ---- verilog/bsp_port.v ----
`timescale 1ns/100ps
`include "bsp_regs.vh"

module bsp_port (
    input  wire                    clk_sys,
    input  wire                    rst,
    input  wire [`BSP_ADDR_W-1:0]  reg_addr,
    input  wire [7:0]              reg_wdata,
    input  wire                    reg_wr,
    input  wire                    reg_rd,
    output reg  [7:0]              reg_rdata,
    output wire                    irq,
    input  wire [7:0]              slave_data_pin_in,
    output wire [7:0]              slave_data_pin_out,
    output wire [7:0]              slave_data_pin_oe,
    input  wire [2:0]              ctrl_pin_in,
    output wire [2:0]              ctrl_pin_out,
    output wire [2:0]              ctrl_pin_oe
);

    // software-visible state
    reg  [7:0]             fourth_port_data;
    reg  [7:0]             fourth_port_direction;
    reg  [2:0]             fifth_port_data;
    reg  [2:0]             ctrl_dir;
    reg                    slave_port_enable;
    reg                    input_buffer_full;
    reg                    output_buffer_full;
    reg                    input_overflow;
    reg  [`BSP_EVT_W-1:0]  evt_status;
    reg  [`BSP_EVT_W-1:0]  evt_mask;

    // slave port state
    reg  [7:0]             input_latch;
    reg                    host_wr_prev;
    reg                    host_rd_prev;

    // synchronised pins
    wire [7:0]             data_pin_s;
    wire [2:0]             ctrl_pin_s;

    // decode
    wire                   sel_data;
    wire                   sel_ctrl_data;
    wire                   sel_dir;
    wire                   sel_ctrl;
    wire                   sel_status;
    wire                   sel_mask;
    wire                   host_sel;
    wire                   host_wr_act;
    wire                   host_rd_act;
    wire                   host_wr_start;
    wire                   host_wr_end;
    wire                   host_rd_start;
    wire                   host_rd_end;
    wire                   cpu_data_rd;
    wire                   cpu_data_wr;
    wire                   wr_dir;
    wire                   wr_ctrl_data;
    wire                   wr_ctrl;
    wire                   wr_status;
    wire                   wr_mask;
    wire                   view_in_full;
    wire                   view_out_full;
    wire [7:0]             data_view;
    wire [7:0]             host_drive;
    wire [`BSP_EVT_W-1:0]  evt_set;
    wire [7:0]             ctrl_view;
    reg  [7:0]             next_rdata;

    bsp_sync #(
        .WIDTH (8),
        .INIT  (`BSP_RST_BYTE)
    ) u_sync_data (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .async_in (slave_data_pin_in),
        .sync_out (data_pin_s)
    );

    bsp_sync #(
        .WIDTH (3),
        .INIT  (`BSP_CTRL_IDLE_PINS)
    ) u_sync_ctrl (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .async_in (ctrl_pin_in),
        .sync_out (ctrl_pin_s)
    );

    assign sel_data      = (reg_addr == `BSP_OFS_DATA);
    assign sel_ctrl_data = (reg_addr == `BSP_OFS_CTRL_DATA);
    assign sel_dir       = (reg_addr == `BSP_OFS_DIR);
    assign sel_ctrl      = (reg_addr == `BSP_OFS_CTRL);
    assign sel_status    = (reg_addr == `BSP_OFS_EVT_STATUS);
    assign sel_mask      = (reg_addr == `BSP_OFS_EVT_MASK);

    assign cpu_data_rd = reg_rd & sel_data;
    assign cpu_data_wr = reg_wr & sel_data;
    assign wr_dir       = reg_wr & sel_dir;
    assign wr_ctrl_data = reg_wr & sel_ctrl_data;
    assign wr_ctrl      = reg_wr & sel_ctrl;
    assign wr_status    = reg_wr & sel_status;
    assign wr_mask      = reg_wr & sel_mask;

    // host side strobes, active low, qualified by chip select
    assign host_sel    = slave_port_enable & ~ctrl_pin_s[`BSP_PIN_CS];
    assign host_wr_act = host_sel & ~ctrl_pin_s[`BSP_PIN_WR];
    assign host_rd_act = host_sel & ~ctrl_pin_s[`BSP_PIN_RD];

    assign host_wr_start = host_wr_act & ~host_wr_prev;
    assign host_rd_start = host_rd_act & ~host_rd_prev;
    assign host_wr_end   = host_wr_prev & ~host_wr_act & slave_port_enable;
    assign host_rd_end   = host_rd_prev & ~host_rd_act & slave_port_enable;

    always @(posedge clk_sys) begin
        if (rst) begin
            host_wr_prev <= `BSP_RST_FLAG;
            host_rd_prev <= `BSP_RST_FLAG;
        end else begin
            host_wr_prev <= host_wr_act;
            host_rd_prev <= host_rd_act;
        end
    end

    // capture the host byte while the write strobe is low
    always @(posedge clk_sys) begin
        if (rst) begin
            input_latch <= `BSP_RST_BYTE;
        end else if (host_wr_act) begin
            input_latch <= data_pin_s;
        end
    end

    // plain registers, one per address
    always @(posedge clk_sys) begin
        if (rst) begin
            fourth_port_data <= `BSP_RST_DATA;
        end else if (cpu_data_wr) begin
            fourth_port_data <= reg_wdata;
        end
    end

    always @(posedge clk_sys) begin
        if (rst) begin
            fourth_port_direction <= `BSP_RST_DIR;
        end else if (wr_dir) begin
            fourth_port_direction <= reg_wdata;
        end
    end

    always @(posedge clk_sys) begin
        if (rst) begin
            fifth_port_data <= `BSP_RST_CTRL_DATA;
        end else if (wr_ctrl_data) begin
            fifth_port_data <= reg_wdata[`BSP_CTRL_DIR_HI:`BSP_CTRL_DIR_LO];
        end
    end

    always @(posedge clk_sys) begin
        if (rst) begin
            ctrl_dir          <= `BSP_RST_CTRL_DIR;
            slave_port_enable <= `BSP_RST_FLAG;
        end else if (wr_ctrl) begin
            ctrl_dir          <= reg_wdata[`BSP_CTRL_DIR_HI:`BSP_CTRL_DIR_LO];
            slave_port_enable <= reg_wdata[`BSP_CTRL_MODE];
        end
    end

    always @(posedge clk_sys) begin
        if (rst) begin
            evt_mask <= `BSP_RST_EVT;
        end else if (wr_mask) begin
            evt_mask <= reg_wdata[`BSP_EVT_W-1:0];
        end
    end

    // input buffer full: set by host write end, cleared by cpu read
    always @(posedge clk_sys) begin
        if (rst) begin
            input_buffer_full <= `BSP_RST_FLAG;
        end else if (!slave_port_enable) begin
            input_buffer_full <= 1'b0;
        end else if (host_wr_end) begin
            input_buffer_full <= 1'b1;
        end else if (cpu_data_rd) begin
            input_buffer_full <= 1'b0;
        end
    end

    // output buffer full: firmware write sets, host read start clears
    always @(posedge clk_sys) begin
        if (rst) begin
            output_buffer_full <= `BSP_RST_FLAG;
        end else if (!slave_port_enable) begin
            output_buffer_full <= 1'b0;
        end else if (cpu_data_wr) begin
            output_buffer_full <= 1'b1;
        end else if (host_rd_start) begin
            output_buffer_full <= 1'b0;
        end
    end

    // overflow: sticky, loaded from ctrl bit 5 on every ctrl write not in the cycle a new overflow sets it, including the one that leaves slave mode
    always @(posedge clk_sys) begin
        if (rst) begin
            input_overflow <= `BSP_RST_FLAG;
        end else if (host_wr_start && input_buffer_full) begin
            input_overflow <= 1'b1;
        end else if (wr_ctrl) begin
            input_overflow <= reg_wdata[`BSP_CTRL_OVF];
        end
    end

    // event status, write one to clear, set wins
    assign evt_set[`BSP_EVT_WRITE_DONE] = host_wr_end;
    assign evt_set[`BSP_EVT_READ_DONE]  = host_rd_end;
    assign evt_set[`BSP_EVT_OVERFLOW]   = host_wr_start & input_buffer_full;

    always @(posedge clk_sys) begin
        if (rst) begin
            evt_status <= `BSP_RST_EVT;
        end else if (wr_status) begin
            evt_status <= (evt_status & ~reg_wdata[`BSP_EVT_W-1:0]) | evt_set;
        end else begin
            evt_status <= evt_status | evt_set;
        end
    end

    assign irq = |(evt_status & evt_mask);

    // full flags read clear from the cycle slave mode is left
    assign view_in_full  = input_buffer_full & slave_port_enable;
    assign view_out_full = output_buffer_full & slave_port_enable;

    // bit 3 always zero
    assign ctrl_view = {view_in_full,
                        view_out_full,
                        input_overflow,
                        slave_port_enable,
                        1'b0,
                        ctrl_dir};

    assign data_view = slave_port_enable ? input_latch : data_pin_s;

    // read data stands one cycle after the strobe only
    always @* begin
        next_rdata = `BSP_RST_BYTE;
        if (reg_rd) begin
            case (reg_addr)
                `BSP_OFS_DATA: begin
                    next_rdata = data_view;
                end
                `BSP_OFS_CTRL_DATA: begin
                    next_rdata = {5'h00, ctrl_pin_s};
                end
                `BSP_OFS_DIR: begin
                    next_rdata = fourth_port_direction;
                end
                `BSP_OFS_CTRL: begin
                    next_rdata = ctrl_view;
                end
                `BSP_OFS_EVT_STATUS: begin
                    next_rdata = {5'h00, evt_status};
                end
                `BSP_OFS_EVT_MASK: begin
                    next_rdata = {5'h00, evt_mask};
                end
                default: begin
                    next_rdata = `BSP_RST_BYTE;
                end
            endcase
        end
    end

    always @(posedge clk_sys) begin
        if (rst) begin
            reg_rdata <= `BSP_RST_BYTE;
        end else begin
            reg_rdata <= next_rdata;
        end
    end

    // pin drive
    assign host_drive         = {8{host_rd_act}};
    assign slave_data_pin_out = fourth_port_data;
    assign slave_data_pin_oe  = slave_port_enable ? host_drive
                                                  : ~fourth_port_direction;
    assign ctrl_pin_out = fifth_port_data;
    assign ctrl_pin_oe  = ~ctrl_dir;

endmodule

// ---- testbench/bsp_port_props.sv ----
`timescale 1ns/100ps
module bsp_port_props (
    input wire       clk_sys,
    input wire       rst,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire       reg_wr,
    input wire       reg_rd,
    input wire [7:0] reg_rdata,
    input wire       irq,
    input wire [7:0] slave_data_pin_in,
    input wire [7:0] slave_data_pin_out,
    input wire [7:0] slave_data_pin_oe,
    input wire [2:0] ctrl_pin_in,
    input wire [2:0] ctrl_pin_out,
    input wire [2:0] ctrl_pin_oe
);
    reg       mode;
    reg [7:0] dir;
    reg [2:0] cdir;
    // shadow of mode and direction bits
    always @(posedge clk_sys) begin
        if (rst) begin
            mode <= 1'b0;
            dir  <= 8'hff;
            cdir <= 3'h7;
        end else if (reg_wr && reg_addr == 8'h89) begin
            mode <= reg_wdata[4];
            cdir <= reg_wdata[2:0];
        end else if (reg_wr && reg_addr == 8'h88) begin
            dir <= reg_wdata;
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    AST_GPIO_OE: assert property (!mode |-> slave_data_pin_oe == ~dir) else $error("gpio enable");
    AST_CTRL_OE: assert property (ctrl_pin_oe == ~cdir) else $error("ctrl enable");
    AST_CS_IDLE: assert property ((mode && ctrl_pin_in[2])[*4] |-> slave_data_pin_oe == 8'h00)
        else $error("driven unselected");
    AST_HOST_RD: assert property ((mode && ctrl_pin_in == 3'b010)[*4] |-> slave_data_pin_oe == 8'hff)
        else $error("not driven in read");
    AST_PIN_OUT: assert property (reg_wr && reg_addr == 8'h08 |=> slave_data_pin_out == $past(reg_wdata))
        else $error("data latch");
    AST_CTL_OUT: assert property (reg_wr && reg_addr == 8'h09 |=>
        {5'h00, ctrl_pin_out} == ($past(reg_wdata) & 8'h07)) else $error("ctrl latch");
    AST_STAT_RD: assert property (reg_rd && reg_addr == 8'h89 |=> !reg_rdata[3]
        && (mode || reg_rdata[7:6] == 2'b00) && reg_rdata[4:0] == {mode, 1'b0, cdir}) else $error("ctrl view");
    AST_RD_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00) else $error("read data lingers");
    cover property (mode && ctrl_pin_in == 3'b101);
    cover property (mode && slave_data_pin_oe == 8'hff);
    cover property (irq);
endmodule

bind bsp_port bsp_port_props CHK (.*);

// ---- testbench/bsp_host.sv ----
`timescale 1ns/100ps
module bsp_host (
    input  wire       clk_sys,
    input  wire [7:0] bus_lvl,
    output reg  [2:0] strb_n,
    output reg  [7:0] hdat
);
    initial begin
        strb_n = 3'h7;
        hdat   = 8'h00;
    end
    // pins {cs_n, wr_n, rd_n}; data held past strobe end
    task xfer(input [2:0] s, input [7:0] d, output [7:0] q);
        @(posedge clk_sys);
        strb_n <= s;
        hdat   <= d;
        repeat (5) @(posedge clk_sys);
        q = bus_lvl;
        strb_n <= 3'h7;
        repeat (3) @(posedge clk_sys);
        hdat <= ~d;
    endtask
endmodule

// ---- testbench/parallel_slave_capable_ports_tb.sv ----
`timescale 1ns/100ps
module parallel_slave_capable_ports_tb;
    reg        clk_sys;
    reg        rst;
    reg  [7:0] reg_addr;
    reg  [7:0] reg_wdata;
    reg        reg_wr;
    reg        reg_rd;
    wire [7:0] reg_rdata;
    wire       irq;
    wire [7:0] slave_data_pin_out;
    wire [7:0] slave_data_pin_oe;
    wire [2:0] ctrl_pin_out;
    wire [2:0] ctrl_pin_oe;
    wire [2:0] strb_n;
    wire [7:0] hdat;
    reg  [7:0] v;
    integer    err_total;
    integer    n_checks;
    integer    cyc;
    wire [7:0] slave_data_pin_in = (slave_data_pin_oe & slave_data_pin_out) | (~slave_data_pin_oe & hdat);
    wire [2:0] ctrl_pin_in = (ctrl_pin_oe & ctrl_pin_out) | (~ctrl_pin_oe & strb_n);

    bsp_port DUT (.*);
    bsp_host HOST (.clk_sys(clk_sys), .bus_lvl(slave_data_pin_in), .strb_n(strb_n), .hdat(hdat));

    task chk(input string nm, input [7:0] e, input [7:0] g);
        n_checks = n_checks + 1;
        if (g !== e) begin
            err_total = err_total + 1;
            $display("ERROR %0s expected %h seen %h", nm, e, g);
        end
    endtask
    task wreg(input [7:0] a, input [7:0] d);
        @(posedge clk_sys);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        #1;
    endtask
    task rchk(input [7:0] a, input [7:0] e);
        @(posedge clk_sys);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        chk($sformatf("reg %h", a), e, reg_rdata);
    endtask
    task t_gpio;
        rchk(8'h89, 8'h07);
        rchk(8'h88, 8'hff);
        rchk(8'h40, 8'h00);
        wreg(8'h88, 8'h0f);
        wreg(8'h08, 8'ha5);
        chk("data oe", 8'hf0, slave_data_pin_oe);
        repeat (3) @(posedge clk_sys);
        rchk(8'h08, 8'ha0);
        wreg(8'h89, 8'hc8);
        rchk(8'h89, 8'h00);
        chk("ctrl oe", 8'h07, {5'h00, ctrl_pin_oe});
        wreg(8'h09, 8'h05);
        chk("ctrl out", 8'h05, {5'h00, ctrl_pin_out});
        repeat (2) @(posedge clk_sys);
        rchk(8'h09, 8'h05);
        wreg(8'h89, 8'h07);
        wreg(8'h88, 8'hff);
        rchk(8'h8a, 8'h00);
        $display("gpio test done");
    endtask
    task t_swr;
        wreg(8'h89, 8'h17);
        HOST.xfer(3'b101, 8'h11, v);
        rchk(8'h89, 8'h17);
        HOST.xfer(3'b001, 8'h3c, v);
        rchk(8'h89, 8'h97);
        wreg(8'h89, 8'h17);
        rchk(8'h89, 8'h97);
        HOST.xfer(3'b001, 8'hc3, v);
        rchk(8'h89, 8'hb7);
        rchk(8'h08, 8'hc3);
        rchk(8'h89, 8'h37);
        wreg(8'h89, 8'h17);
        rchk(8'h89, 8'h17);
        $display("host write test done");
    endtask
    task t_srd;
        wreg(8'h08, 8'h69);
        rchk(8'h89, 8'h57);
        HOST.xfer(3'b010, 8'h00, v);
        chk("host byte", 8'h69, v);
        rchk(8'h89, 8'h17);
        $display("host read test done");
    endtask
    task t_irq;
        rchk(8'h8a, 8'h07);
        chk("irq", 8'h00, {7'h00, irq});
        wreg(8'h8b, 8'h02);
        chk("irq", 8'h01, {7'h00, irq});
        wreg(8'h8a, 8'h07);
        chk("irq", 8'h00, {7'h00, irq});
        rchk(8'h8a, 8'h00);
        $display("irq test done");
    endtask
    task t_leave;
        wreg(8'h08, 8'h5a);
        HOST.xfer(3'b001, 8'h77, v);
        rchk(8'h89, 8'hd7);
        HOST.xfer(3'b001, 8'h78, v);
        rchk(8'h89, 8'hf7);
        wreg(8'h89, 8'h27);
        rchk(8'h89, 8'h27);
        $display("leave mode test done");
    endtask
    task wrap_up;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cyc = cyc + 1;
        if (cyc == 2000) begin
            err_total = err_total + 1;
            wrap_up;
        end
    end
    initial begin
        rst       = 1'b1;
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        err_total = 0;
        n_checks  = 0;
        cyc       = 0;
        repeat (6) @(posedge clk_sys);
        rst <= 1'b0;
        t_gpio;
        t_swr;
        t_srd;
        t_irq;
        t_leave;
        wrap_up;
    end
endmodule
